/* File: hdl/osc_pkg.sv */
// constants shared by the octal switch channel control block
`default_nettype none
package osc_pkg;
	localparam int NUM_CH = 8;
	localparam int CLK_MHZ = 100;
	// register byte offsets
	localparam logic [7:0] OFF_MAP = 8'h00;
	localparam logic [7:0] OFF_COMBINE = 8'h04;
	localparam logic [7:0] OFF_OVERLOAD = 8'h08;
	localparam logic [7:0] OFF_OVERTEMP = 8'h0c;
	localparam logic [7:0] OFF_SLEW = 8'h10;
	localparam logic [7:0] OFF_STATUS = 8'h14;
	localparam logic [7:0] OFF_CONTROL = 8'h18;
	localparam logic [7:0] OFF_DIAG = 8'h1c;
	// reset values
	localparam logic [7:0] MAP_RST = 8'h08;
	localparam logic [7:0] CFG_RST = 8'h00;
	// timing
	localparam int FAULT_FILTER_NS = 100000;
	localparam int OVL_OFF_NS = 30000;
	localparam int FAULT_FILTER_CYC = (FAULT_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int OVL_OFF_CYC = (OVL_OFF_NS * CLK_MHZ + 999) / 1000;
	localparam int SPI_BITS = 16;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

/* File: hdl/osc_sync3.sv */
// three-stage input synchroniser with agreement filter
`default_nettype none
module osc_sync3 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// levels
	input wire logic [W-1:0] async,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q, s2_q, s3_q, out_q;

	// a change counts once stages two and three agree
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			out_q <= RST;
		end else begin
			s1_q <= async;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end

	assign level = out_q;
endmodule
`default_nettype wire

/* File: hdl/osc_channel.sv */
// protection and latch logic of one switch channel
`default_nettype none
module osc_channel #(
	parameter int CNT_W = 16,
	parameter int FILTER_CYC = 10000,
	parameter int OFF_CYC = 3000
) (
	// clock and reset (also held during sleep)
	input wire logic clk,
	input wire logic reset,
	// control
	input wire logic cmdOn,
	input wire logic ovlShutdown,
	input wire logic otLatch,
	input wire logic clearDiag,
	// power stage sensors
	input wire logic overtemp,
	input wire logic limitActive,
	// state
	output logic driveOn,
	output logic diagOt,
	output logic diagOl
);
	logic prev_q, otOff_q, olOff_q, driveOn_q, diagOt_q, diagOl_q;
	logic otOff_d, olOff_d, driveOn_d, diagOt_d, diagOl_d;
	logic [CNT_W-1:0] limCnt_q, limCnt_d;

	wire rise = cmdOn & ~prev_q; // RULE25
	wire otSense = overtemp & driveOn_q; // RULE11
	wire limRun = limitActive & driveOn_q;
	wire filterDone = limCnt_q >= CNT_W'(FILTER_CYC); // RULE22
	wire offDone = limCnt_q >= CNT_W'(OFF_CYC); // RULE21
	wire olTrip = ovlShutdown & limRun & offDone; // RULE16

	always_comb begin
		limCnt_d = '0;
		if (limRun) begin
			limCnt_d = (&limCnt_q) ? limCnt_q : limCnt_q + 1'b1;
		end
		otOff_d = otOff_q;
		if (otSense) begin
			otOff_d = 1'b1; // RULE8
		end else if (otLatch) begin
			if (rise) begin
				otOff_d = 1'b0; // RULE10
			end
		end else if (!overtemp) begin
			otOff_d = 1'b0; // RULE9
		end
		olOff_d = olTrip | (olOff_q & ~rise); // RULE17
		driveOn_d = cmdOn & ~otOff_d & ~olOff_d; // RULE15
		diagOt_d = otSense | (diagOt_q & ~clearDiag); // RULE8
		diagOl_d = (limRun & filterDone) | olTrip | (diagOl_q & ~clearDiag); // RULE15
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			prev_q <= 1'b0;
			otOff_q <= 1'b0;
			olOff_q <= 1'b0;
			driveOn_q <= 1'b0;
			diagOt_q <= 1'b0;
			diagOl_q <= 1'b0;
			limCnt_q <= '0;
		end else begin
			prev_q <= cmdOn;
			otOff_q <= otOff_d;
			olOff_q <= olOff_d;
			driveOn_q <= driveOn_d;
			diagOt_q <= diagOt_d;
			diagOl_q <= diagOl_d;
			limCnt_q <= limCnt_d;
		end
	end

	assign driveOn = driveOn_q;
	assign diagOt = diagOt_q;
	assign diagOl = diagOl_q;
endmodule
`default_nettype wire

/* File: hdl/osc_top.sv */
// octal low-side switch channel control with AXI4-Lite registers and serial port
//
// Behaviour
// [RULE1] each channel combines serial and parallel by AND/OR
// [RULE2] serial high active; parallel polarity from select pin
// [RULE3] floating polarity select acts as high
// [RULE4] floating parallel inputs keep channels 1-4 off
// [RULE5] mappable input drives every mapped channel
// [RULE6] map resets to channel 4 only
// [RULE7] per channel fast or slow switching profile
// [RULE8] overtemperature turns channel off, records diagnosis
// [RULE9] auto restart after cooling if input on
// [RULE10] latching overtemperature cleared by input rise
// [RULE11] overtemperature evaluated only while channel on
// [RULE12] sleep: outputs off, diagnosis and control cleared
// [RULE13] sleep clears serial shift register
// [RULE14] after sleep only parallel-driven outputs switch on
// [RULE15] limit-only mode reports fault, keeps channel on
// [RULE16] shutdown mode turns channel off after delay
// [RULE17] overload latch cleared by effective input rise
// [RULE18] fault flag pulls low on any latched error
// [RULE19] host keeps chip select high between accesses
// [RULE20] host serial clock at most 5 MHz
// [RULE21] overload switch-off delay within 10 to 50 us
// [RULE22] fault must persist filter time before latching; code filters limit mode only, overtemp at once, shutdown at OFF_CYC
// [RULE23] combine bit 0 is OR, 1 is AND
// [RULE24] overtemp bit 0 auto restart, 1 latching
// [RULE25] input rise detected synchronously after combination
// [RULE26] fault flag held until valid access or reset
`default_nettype none
module osc_top
	import osc_pkg::*;
#(
	parameter int FILTER_CYC = FAULT_FILTER_CYC,
	parameter int OFF_CYC = OVL_OFF_CYC,
	parameter int CNT_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial port pins
	input wire logic spiCsN,
	input wire logic spiSclk,
	input wire logic spiSi,
	output logic spiSoOut,
	output logic spiSoOe,
	// sleep pin, low active
	input wire logic sleepPinN,
	// parallel pins
	input wire logic inputPolaritySelect,
	input wire logic polaritySelectFloat,
	input wire logic [2:0] fixedParallelInputs,
	input wire logic mappableParallelInput,
	input wire logic [3:0] parallelInputsFloat,
	// power stage sensors
	input wire logic [NUM_CH-1:0] overtempSense,
	input wire logic [NUM_CH-1:0] currentLimitSense,
	// power stage drive
	output logic [NUM_CH-1:0] channelDrainOutputs,
	output logic [NUM_CH-1:0] slowSwitching,
	// open-drain fault flag
	output logic faultOut,
	output logic faultOe
);
	if (FILTER_CYC < 1 || OFF_CYC < 1 || FILTER_CYC >= 2 ** CNT_W || OFF_CYC >= 2 ** CNT_W) begin : g_chk
		$error("osc_top: counts do not fit the counter width");
	end

	// ----------------------------------------------------------------
	// input synchronisation
	// ----------------------------------------------------------------
	localparam int SYNC_W = 14 + 2 * NUM_CH;
	localparam logic [SYNC_W-1:0] SYNC_RST = {5'b10011, 9'h000, {2 * NUM_CH{1'b0}}};
	logic [SYNC_W-1:0] syncLvl;
	logic csN, sclk, si, sleepN, prgLvl, prgFloat;
	logic [3:0] parLvl, parFloat;
	logic [NUM_CH-1:0] otLvl, limLvl;

	// serial pins share one chain, so clock and data keep their relative timing
	osc_sync3 #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
		.clk(clk),
		.reset(reset),
		.async({spiCsN, spiSclk, spiSi, sleepPinN, inputPolaritySelect, polaritySelectFloat,
			mappableParallelInput, fixedParallelInputs, parallelInputsFloat, overtempSense, currentLimitSense}),
		.level(syncLvl)
	);
	assign {csN, sclk, si, sleepN, prgLvl, prgFloat, parLvl, parFloat, otLvl, limLvl} = syncLvl;

	wire sleep = ~sleepN;
	wire chanReset = reset | sleep; // RULE12

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	logic [7:0] map_q, combine_q, overload_q, overtemp_q, slew_q, control_q;
	logic [NUM_CH-1:0] drive, diagOt, diagOl, driveOut_q, slow_q;
	logic clearDiag;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q, faultOe_q;
	logic [1:0] bResp_q, rResp_q;
	logic [7:0] awAddr_q;
	logic [31:0] wData_q, rData_q;
	logic wStrb0_q;
	// address and data may arrive in either order; each ready stays low
	// until the response is taken, so only one write is ever in flight

	wire awFire = s_axi_awvalid & awReady_q;
	wire wFire = s_axi_wvalid & wReady_q;
	wire haveAw = ~awReady_q;
	wire haveW = ~wReady_q;
	wire doWrite = haveAw & haveW & ~bValid_q;
	wire [5:0] wIdx = awAddr_q[7:2];
	wire wrMap = doWrite & wStrb0_q & (wIdx == OFF_MAP[7:2]);
	wire wrComb = doWrite & wStrb0_q & (wIdx == OFF_COMBINE[7:2]);
	wire wrOvl = doWrite & wStrb0_q & (wIdx == OFF_OVERLOAD[7:2]);
	wire wrOvt = doWrite & wStrb0_q & (wIdx == OFF_OVERTEMP[7:2]);
	wire wrSlew = doWrite & wStrb0_q & (wIdx == OFF_SLEW[7:2]);
	wire wrCtl = doWrite & wStrb0_q & (wIdx == OFF_CONTROL[7:2]);
	wire wrKnown = (wIdx <= OFF_DIAG[7:2]);

	wire arFire = s_axi_arvalid & arReady_q;
	wire [5:0] rIdx = s_axi_araddr[7:2];
	wire rdKnown = (rIdx <= OFF_DIAG[7:2]);
	wire [31:0] rdMux =
		(rIdx == OFF_MAP[7:2]) ? {24'h000000, map_q} :
		(rIdx == OFF_COMBINE[7:2]) ? {24'h000000, combine_q} :
		(rIdx == OFF_OVERLOAD[7:2]) ? {24'h000000, overload_q} :
		(rIdx == OFF_OVERTEMP[7:2]) ? {24'h000000, overtemp_q} :
		(rIdx == OFF_SLEW[7:2]) ? {24'h000000, slew_q} :
		(rIdx == OFF_STATUS[7:2]) ? {24'h000000, driveOut_q} :
		(rIdx == OFF_CONTROL[7:2]) ? {24'h000000, control_q} :
		(rIdx == OFF_DIAG[7:2]) ? {16'h0000, diagOl, diagOt} : 32'h00000000;

	always_ff @(posedge clk) begin
		if (reset) begin
			awReady_q <= 1'b1;
			wReady_q <= 1'b1;
			bValid_q <= 1'b0;
			bResp_q <= RESP_OKAY;
			awAddr_q <= 8'h00;
			wData_q <= 32'h00000000;
			wStrb0_q <= 1'b0;
		end else begin
			if (awFire) begin
				awReady_q <= 1'b0;
				awAddr_q <= s_axi_awaddr;
			end
			if (wFire) begin
				wReady_q <= 1'b0;
				wData_q <= s_axi_wdata;
				wStrb0_q <= s_axi_wstrb[0];
			end
			if (doWrite) begin
				bValid_q <= 1'b1;
				bResp_q <= wrKnown ? RESP_OKAY : RESP_SLVERR;
			end
			if (bValid_q && s_axi_bready) begin
				bValid_q <= 1'b0;
				awReady_q <= 1'b1;
				wReady_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arReady_q <= 1'b1;
			rValid_q <= 1'b0;
			rData_q <= 32'h00000000;
			rResp_q <= RESP_OKAY;
		end else if (arFire) begin
			arReady_q <= 1'b0;
			rValid_q <= 1'b1;
			rData_q <= rdMux;
			rResp_q <= rdKnown ? RESP_OKAY : RESP_SLVERR;
		end else if (rValid_q && s_axi_rready) begin
			rValid_q <= 1'b0;
			arReady_q <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			map_q <= MAP_RST; // RULE6
			combine_q <= CFG_RST;
			overload_q <= CFG_RST;
			overtemp_q <= CFG_RST;
			slew_q <= CFG_RST;
		end else begin
			if (wrMap) map_q <= wData_q[7:0];
			if (wrComb) combine_q <= wData_q[7:0];
			if (wrOvl) overload_q <= wData_q[7:0];
			if (wrOvt) overtemp_q <= wData_q[7:0];
			if (wrSlew) slew_q <= wData_q[7:0];
		end
	end

	// serial on/off bits are lost in sleep
	always_ff @(posedge clk) begin
		if (chanReset) begin
			control_q <= CFG_RST; // RULE12
		end else if (wrCtl) begin
			control_q <= wData_q[7:0];
		end
	end

	// ----------------------------------------------------------------
	// serial port: shift register and diagnosis readout
	// ----------------------------------------------------------------
	logic [SPI_BITS-1:0] shift_q, diagWord;
	logic [4:0] bitCnt_q;
	logic csPrev_q, sclkPrev_q, soOut_q, soOe_q, clear_q;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_diagWord
		assign diagWord[2 * c + 1 -: 2] = {~diagOl[c], ~diagOt[c]};
	end

	wire csFall = csPrev_q & ~csN;
	wire csRise = ~csPrev_q & csN;
	wire sclkFall = sclkPrev_q & ~sclk & ~csN;
	wire sclkRise = ~sclkPrev_q & sclk & ~csN;
	wire frameOk = (bitCnt_q[2:0] == 3'b000) & (bitCnt_q != 5'd0);
	// data out moves on the serial clock rise and holds until the next rise,
	// so a host reads it late in the period, after the fall

	always_ff @(posedge clk) begin
		if (chanReset) begin
			shift_q <= '0; // RULE13
			bitCnt_q <= 5'd0;
			csPrev_q <= 1'b1;
			sclkPrev_q <= 1'b0;
			soOut_q <= 1'b0;
			soOe_q <= 1'b0;
			clear_q <= 1'b0;
		end else begin
			csPrev_q <= csN;
			sclkPrev_q <= sclk;
			soOe_q <= ~csN;
			clear_q <= csRise & frameOk; // RULE26
			if (csFall) begin
				shift_q <= diagWord;
				bitCnt_q <= 5'd0;
				soOut_q <= diagWord[SPI_BITS-1];
			end else if (sclkFall) begin
				shift_q <= {shift_q[SPI_BITS-2:0], si};
				bitCnt_q <= bitCnt_q + 5'd1;
			end else if (sclkRise) begin
				soOut_q <= shift_q[SPI_BITS-1];
			end
		end
	end
	assign clearDiag = clear_q;

	// ----------------------------------------------------------------
	// input conditioning and channel combination
	// ----------------------------------------------------------------
	// open pins read as inactive whatever the polarity, so a missing
	// harness cannot switch a load on
	wire polarityHigh = prgFloat | prgLvl; // RULE3
	wire [3:0] parActive = ~parFloat & (polarityHigh ? parLvl : ~parLvl); // RULE2 RULE4
	logic [NUM_CH-1:0] chanPar, chanCmd;

	for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
		if (c < 3) begin : g_fixed
			assign chanPar[c] = parActive[c] | (map_q[c] & parActive[3]); // RULE5
		end else begin : g_mapped
			assign chanPar[c] = map_q[c] & parActive[3]; // RULE5
		end
		// serial bit cleared in sleep, so only parallel drive survives
		assign chanCmd[c] = combine_q[c] ? (control_q[c] & chanPar[c]) : (control_q[c] | chanPar[c]); // RULE1 RULE23 RULE14

		osc_channel #(.CNT_W(CNT_W), .FILTER_CYC(FILTER_CYC), .OFF_CYC(OFF_CYC)) u_ch (
			.clk(clk),
			.reset(chanReset),
			.cmdOn(chanCmd[c]),
			.ovlShutdown(overload_q[c]),
			.otLatch(overtemp_q[c]), // RULE24
			.clearDiag(clearDiag),
			.overtemp(otLvl[c]),
			.limitActive(limLvl[c]),
			.driveOn(drive[c]),
			.diagOt(diagOt[c]),
			.diagOl(diagOl[c])
		);
	end

	// ----------------------------------------------------------------
	// output registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (chanReset) begin
			driveOut_q <= '0; // RULE12
			slow_q <= '0;
			faultOe_q <= 1'b0;
		end else begin
			driveOut_q <= drive;
			slow_q <= slew_q; // RULE7
			faultOe_q <= |{diagOt, diagOl}; // RULE18
		end
	end

	assign channelDrainOutputs = driveOut_q;
	assign slowSwitching = slow_q;
	// open drain: value tied low, the enable pulls the line
	assign faultOut = 1'b0;
	assign faultOe = faultOe_q;
	assign spiSoOut = soOut_q;
	assign spiSoOe = soOe_q;
	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
endmodule
`default_nettype wire

/* File: tb/osc_host_model.sv */
// host side model: serial frames on the four-wire port
`default_nettype none
module osc_host_model #(
	parameter int HALF_NS = 100
) (
	// request
	input wire logic start,
	input wire logic [4:0] numBits,
	// serial pins
	output logic spiCsN,
	output logic spiSclk,
	output logic spiSi,
	input wire logic soLine,
	// result
	output logic [15:0] soWord,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		spiCsN = 1'b1;
		spiSclk = 1'b0;
		spiSi = 1'b0;
		soWord = 16'h0000;
		busy = 1'b0;
		forever begin
			@(posedge start);
			// keep pin changes off the sampling clock edges
			#2;
			busy = 1'b1;
			spiCsN = 1'b0;
			#300;
			for (int i = 0; i < numBits; i++) begin
				spiSclk = 1'b1;
				spiSi = 1'($urandom());
				#HALF_NS;
				spiSclk = 1'b0;
				#HALF_NS;
				// so moves on the rise and is settled by the end of the period
				soWord = {soWord[14:0], soLine};
			end
			#300;
			spiCsN = 1'b1;
			// si line falls to its pull-down once deselected
			spiSi = 1'b0;
			#300;
			busy = 1'b0;
		end
	end
endmodule
`default_nettype wire

/* File: tb/osc_top_chk.sv */
// assertions on the ports of the channel control block
`default_nettype none
module osc_top_chk #(
	parameter int FILTER_CYC = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// pins
	input wire logic spiCsN,
	input wire logic spiSoOe,
	input wire logic sleepPinN,
	input wire logic [7:0] overtempSense,
	input wire logic [7:0] currentLimitSense,
	input wire logic [7:0] channelDrainOutputs,
	input wire logic faultOe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] limCnt_q;
	logic [15:0] limCnt_d;
	assign limCnt_d = (|currentLimitSense && spiCsN && sleepPinN) ? limCnt_q + 16'h0001 : 16'h0000;
	always_ff @(posedge clk) begin
		if (reset) begin
			limCnt_q <= 16'h0000;
		end else begin
			limCnt_q <= limCnt_d;
		end
	end
	// cycles in a row with select and sleep pins both high
	logic [3:0] hiCnt_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			hiCnt_q <= 4'h0;
		end else if (!(spiCsN && sleepPinN)) begin
			hiCnt_q <= 4'h0;
		end else if (hiCnt_q != 4'hf) begin
			hiCnt_q <= hiCnt_q + 4'h1;
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_sleep_off: assert property ((!sleepPinN)[*8] |-> channelDrainOutputs == 8'h00)
		else $error("channel on in sleep");
	chk_sleep_flag: assert property ((!sleepPinN)[*8] |-> !faultOe)
		else $error("fault flag in sleep");
	chk_so_release: assert property (spiCsN[*8] |-> !spiSoOe)
		else $error("serial out driven while deselected");
	chk_ot_shut: assert property (not ((|(overtempSense & channelDrainOutputs))[*8]))
		else $error("hot channel left on");
	chk_ot_flag: assert property ((|(overtempSense & channelDrainOutputs))[*5] |-> ##[0:4] faultOe)
		else $error("overtemperature not flagged");
	chk_flag_hold: assert property (spiCsN && sleepPinN && hiCnt_q >= 4'hb && faultOe |=> faultOe)
		else $error("fault flag released without frame");
	chk_limit_flag: assert property (limCnt_q == FILTER_CYC + 12 |-> faultOe)
		else $error("current limit not flagged");
endmodule
bind osc_top osc_top_chk #(.FILTER_CYC(FILTER_CYC)) chk_i (.*);
`default_nettype wire

/* File: tb/test_osc_top.sv */
// self-checking bench of the octal switch channel control block
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		checks_done++; \
		if ((g) !== (e)) begin \
			num_errors++; \
			$display("Error %s expected %h seen %h", nm, e, g); \
		end \
	end
module test_osc_top
	import osc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FLT = 20;
	localparam int OFFC = 8;
	int num_errors = 0, checks_done = 0;
	logic clk = 1'b0, reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, lastResp;
	logic spiCsN, spiSclk, spiSi, spiSoOut, spiSoOe, faultOut, faultOe, hostStart = 1'b0, hostBusy;
	logic sleepPinN = 1'b1, inputPolaritySelect = 1'b1, polaritySelectFloat = 1'b0, mappableParallelInput = 1'b0;
	logic [2:0] fixedParallelInputs = 3'h0;
	logic [3:0] parallelInputsFloat = 4'hf;
	logic [4:0] hostBits = 5'h10;
	logic [7:0] overtempSense = 8'h00, currentLimitSense = 8'h00, channelDrainOutputs, slowSwitching;
	logic [15:0] hostWord;
	wire logic soLine;
	assign soLine = spiSoOe ? spiSoOut : 1'bz;
	osc_top #(.FILTER_CYC(FLT), .OFF_CYC(OFFC)) dut (.*);
	osc_host_model host (.start(hostStart), .numBits(hostBits), .spiCsN(spiCsN), .spiSclk(spiSclk),
		.spiSi(spiSi), .soLine(soLine), .soWord(hostWord), .busy(hostBusy));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		lastResp = s_axi_bresp;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		lastResp = s_axi_rresp;
	endtask
	task automatic frame(input logic [4:0] n);
		hostBits <= n;
		hostStart <= 1'b1;
		tick(2);
		hostStart <= 1'b0;
		while (hostBusy) @(posedge clk);
	endtask
	function automatic logic [7:0] exp_out(input logic [7:0] m, input logic [7:0] b, input logic [7:0] s);
		logic [7:0] par;
		logic p;
		p = polaritySelectFloat | inputPolaritySelect;
		par = 8'h00;
		for (int c = 0; c < 3; c++)
			par[c] = !parallelInputsFloat[c] && (fixedParallelInputs[c] == p);
		par = par | (m & {8{!parallelInputsFloat[3] && (mappableParallelInput == p)}});
		return (b & par & s) | (~b & (par | s));
	endfunction
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#300000;
		num_errors++;
		print_verdict();
	end
	initial begin
		logic [31:0] rd;
		logic [7:0] mp, cb, ct;
		void'($urandom(99));
		tick(16);
		reset <= 1'b0;
		tick(6);
		axi_rd(OFF_MAP, rd);
		`CHK("map reset", 32'h00000008, rd)
		axi_rd(OFF_COMBINE, rd);
		`CHK("combine reset", 32'h00000000, rd)
		axi_rd(8'h20, rd);
		`CHK("unmapped read", RESP_SLVERR, lastResp)
		axi_wr(8'h20, 32'h000000ff);
		`CHK("unmapped write", RESP_SLVERR, lastResp)
		axi_rd(OFF_MAP, rd);
		`CHK("map kept", 32'h00000008, rd)
		$display("test registers done");
		for (int i = 0; i < 24; i++) begin
			mp = 8'($urandom());
			cb = 8'($urandom());
			ct = (i == 0) ? 8'h00 : 8'($urandom());
			inputPolaritySelect <= (i == 1) ? 1'b0 : 1'($urandom());
			polaritySelectFloat <= (i == 1) || ($urandom_range(3) == 0);
			fixedParallelInputs <= 3'($urandom());
			mappableParallelInput <= 1'($urandom());
			parallelInputsFloat <= (i == 0) ? 4'hf : 4'($urandom() & $urandom());
			axi_wr(OFF_MAP, {24'h0, mp});
			axi_wr(OFF_COMBINE, {24'h0, cb});
			axi_wr(OFF_CONTROL, {24'h0, ct});
			axi_wr(OFF_SLEW, {24'h0, ct ^ mp});
			`CHK("write resp", RESP_OKAY, lastResp)
			tick(8);
			`CHK("outputs", exp_out(mp, cb, ct), channelDrainOutputs)
			`CHK("slew", ct ^ mp, slowSwitching)
			axi_rd(OFF_STATUS, rd);
			`CHK("status", {24'h0, exp_out(mp, cb, ct)}, rd)
		end
		$display("test combination done");
		parallelInputsFloat <= 4'hf;
		axi_wr(OFF_COMBINE, 32'h0);
		axi_wr(OFF_OVERTEMP, 32'h1);
		axi_wr(OFF_CONTROL, 32'h1);
		frame(5'd16);
		overtempSense <= 8'h01;
		tick(12);
		`CHK("hot off", 1'b0, channelDrainOutputs[0])
		`CHK("hot flag", 1'b1, faultOe)
		overtempSense <= 8'h00;
		tick(12);
		`CHK("hot latched", 1'b0, channelDrainOutputs[0])
		axi_wr(OFF_CONTROL, 32'h0);
		axi_wr(OFF_CONTROL, 32'h1);
		tick(6);
		`CHK("hot relaunch", 1'b1, channelDrainOutputs[0])
		axi_wr(OFF_OVERTEMP, 32'h0);
		overtempSense <= 8'h01;
		tick(20);
		overtempSense <= 8'h00;
		tick(12);
		`CHK("hot auto", 1'b1, channelDrainOutputs[0])
		frame(5'd16);
		`CHK("hot cleared", 1'b0, faultOe)
		overtempSense <= 8'h02;
		tick(12);
		`CHK("hot idle ch", 1'b0, faultOe)
		overtempSense <= 8'h00;
		$display("test overtemperature done");
		axi_wr(OFF_CONTROL, 32'h4);
		currentLimitSense <= 8'h04;
		tick(FLT / 2);
		`CHK("limit early", 1'b0, faultOe)
		tick(FLT + 16);
		`CHK("limit flag", 1'b1, faultOe)
		`CHK("limit kept on", 1'b1, channelDrainOutputs[2])
		axi_rd(OFF_DIAG, rd);
		`CHK("diag reg", 32'h00000400, rd)
		currentLimitSense <= 8'h00;
		frame(5'd12);
		`CHK("short frame", 1'b1, faultOe)
		frame(5'd16);
		`CHK("diag word", 16'hffdf, hostWord)
		`CHK("limit cleared", 1'b0, faultOe)
		axi_wr(OFF_OVERLOAD, 32'h4);
		currentLimitSense <= 8'h04;
		tick(OFFC + 8);
		`CHK("limit shut", 1'b0, channelDrainOutputs[2])
		currentLimitSense <= 8'h00;
		tick(12);
		`CHK("limit latched", 1'b0, channelDrainOutputs[2])
		axi_wr(OFF_CONTROL, 32'h0);
		axi_wr(OFF_CONTROL, 32'h4);
		tick(6);
		`CHK("limit relaunch", 1'b1, channelDrainOutputs[2])
		$display("test overload done");
		axi_wr(OFF_MAP, 32'h0);
		inputPolaritySelect <= 1'b1;
		polaritySelectFloat <= 1'b0;
		parallelInputsFloat <= 4'h0;
		fixedParallelInputs <= 3'b001;
		mappableParallelInput <= 1'b0;
		axi_wr(OFF_CONTROL, 32'hff);
		sleepPinN <= 1'b0;
		tick(10);
		`CHK("sleep outputs", 8'h00, channelDrainOutputs)
		sleepPinN <= 1'b1;
		tick(10);
		`CHK("wake outputs", 8'h01, channelDrainOutputs)
		axi_rd(OFF_CONTROL, rd);
		`CHK("wake control", 32'h0, rd)
		$display("test sleep done");
		print_verdict();
	end
endmodule
`default_nettype wire
